// ---- core/timer8_defs.vh ----
// Purpose: Constants for the 8-bit waveform timer block
// Assumes: 25 MHz ref_clk, Avalon-MM byte addressing of word-aligned registers
// Notes: Offsets are byte addresses of 32-bit words
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL_A 5'h00
`define OFS_CTRL_B 5'h04
`define OFS_COUNT 5'h08
`define OFS_MATCH_A 5'h0c
`define OFS_STATUS 5'h01 // Index form unused; status lives at OFS_FLAGS
`define OFS_FLAGS 5'h10
`define OFS_MATCH_B 5'h14

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define CTRLA_WMASK 8'hf3
`define CTRLB_WMASK 8'h0f
`define FB_FORCE_A 7
`define FB_FORCE_B 6
`define FB_MODE_HIGH 3

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define CTRL_RST 8'h00
`define CNT_MAX 8'hff
`define CNT_BOTTOM 8'h00

// ----------------------------------------
// Waveform modes
// ----------------------------------------
`define WM_NORMAL 3'h0
`define WM_PC_FF 3'h1
`define WM_CTC 3'h2
`define WM_FAST_FF 3'h3
`define WM_PC_A 3'h5
`define WM_FAST_A 3'h7

`endif

// ---- core/tick_select.v ----
// Purpose: Timer tick source selection and prescaler
// Assumes: ext_tick_pin already synchronised by the caller
// Notes: Prescaler free-runs; a stopped source yields no ticks
`timescale 1ns/100ps
module tick_select (
  ref_clk,
  rst_n,
  tick_source_sel,
  ext_sync,
  tick
);
  input wire ref_clk;
  input wire rst_n;
  input wire [2:0] tick_source_sel;
  input wire ext_sync;
  output reg tick;

  reg [9:0] div_ff;
  reg ext_prev_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 10'h000;
      ext_prev_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 10'h001;
      ext_prev_ff <= ext_sync;
    end
  end

  // Divide ratios 8, 64, 256, 1024 taken from the shared prescaler
  always @* begin
    case (tick_source_sel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (div_ff[2:0] == 3'h7);
      3'h3: tick = (div_ff[5:0] == 6'h3f);
      3'h4: tick = (div_ff[7:0] == 8'hff);
      3'h5: tick = (div_ff == 10'h3ff);
      3'h6: tick = ext_prev_ff & ~ext_sync;
      default: tick = ~ext_prev_ff & ext_sync;
    endcase
  end
endmodule // tick_select

// ---- core/wave_out_unit.v ----
// Purpose: One compare output channel action logic
// Assumes: Mode decode flags from the timer core
// Notes: B channel passes allow_toggle low so its code 01 stays reserved in PWM modes
`timescale 1ns/100ps
module wave_out_unit (
  ref_clk,
  rst_n,
  sel,
  allow_toggle,
  is_pwm,
  is_pc,
  count_up,
  match,
  at_top,
  at_bottom,
  match_is_top,
  force_hit,
  wave_out,
  drive_en
);
  input wire ref_clk;
  input wire rst_n;
  input wire [1:0] sel;
  input wire allow_toggle;
  input wire is_pwm;
  input wire is_pc;
  input wire count_up;
  input wire match;
  input wire at_top;
  input wire at_bottom;
  input wire match_is_top;
  input wire force_hit;
  output reg wave_out;
  output reg drive_en;

  reg nxt_wave;
  reg hit;

  always @* begin
    nxt_wave = wave_out;
    hit = match | force_hit;
    if (!is_pwm) begin
      case (sel)
        2'h1: if (hit) nxt_wave = ~wave_out;
        2'h2: if (hit) nxt_wave = 1'b0;
        2'h3: if (hit) nxt_wave = 1'b1;
        default: nxt_wave = wave_out;
      endcase
    end else if (sel == 2'h1) begin
      if (allow_toggle && match) nxt_wave = ~wave_out;
    end else if (sel[1]) begin
      if (match_is_top) begin
        // Match ignored; the top action keeps the output at its steady level
        if (at_top) nxt_wave = ~sel[0];
      end else if (!is_pc) begin
        if (match) nxt_wave = sel[0];
        else if (at_top) nxt_wave = ~sel[0];
      end else if (match) begin
        nxt_wave = count_up ? sel[0] : ~sel[0];
      end else if (at_bottom) begin
        nxt_wave = ~sel[0];
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_out <= 1'b0;
      drive_en <= 1'b0;
    end else begin
      wave_out <= nxt_wave;
      // Reserved code 01 on channel B in PWM keeps the pin released
      drive_en <= (sel != 2'h0) && !(is_pwm && sel == 2'h1 && !allow_toggle);
    end
  end
endmodule // wave_out_unit

// ---- core/timer8_wave_ctrl.v ----
// Purpose: 8-bit timer waveform mode control with Avalon-MM register slave
// Assumes: 25 MHz ref_clk; ext_tick_pin is asynchronous to ref_clk
// Notes: Pin direction registers live outside; drive_en only requests the pin
`timescale 1ns/100ps
`include "timer8_defs.vh"
module timer8_wave_ctrl (
  ref_clk,
  arst_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  ext_tick_pin,
  wave_out_a,
  wave_out_b,
  drive_en_a,
  drive_en_b
);
  input wire ref_clk;
  input wire arst_n;
  input wire [4:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  output reg [31:0] avs_readdata;
  output reg avs_waitrequest;
  input wire ext_tick_pin;
  output wire wave_out_a;
  output wire wave_out_b;
  output wire drive_en_a;
  output wire drive_en_b;

  // ----------------------------------------
  // Reset and pin synchronisers
  // ----------------------------------------
  reg rst_meta_ff;
  reg rst_n_ff;
  reg ext_meta_ff;
  reg ext_sync_ff;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  always @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
    end else begin
      ext_meta_ff <= ext_tick_pin;
      ext_sync_ff <= ext_meta_ff;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] ctrl_a_ff;
  reg [7:0] ctrl_b_ff;
  reg [7:0] count_value_ff;
  reg [7:0] match_value_a_ff;
  reg [7:0] match_value_b_ff;
  reg [7:0] match_buf_a_ff;
  reg [7:0] match_buf_b_ff;
  reg count_up_ff;
  reg wrap_flag_ff;
  reg match_flag_a_ff;
  reg match_flag_b_ff;
  reg force_a_ff;
  reg force_b_ff;
  reg count_wr_ff;

  wire tick;
  wire [1:0] out_a_action_sel = ctrl_a_ff[7:6];
  wire [1:0] out_b_action_sel = ctrl_a_ff[5:4];
  wire [1:0] wave_mode_low = ctrl_a_ff[1:0];
  wire wave_mode_high = ctrl_b_ff[`FB_MODE_HIGH];
  wire [2:0] tick_source_sel = ctrl_b_ff[2:0];
  wire [2:0] wave_mode = {wave_mode_high, wave_mode_low};

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Reserved modes 4 and 6 fall through to plain normal counting
  wire is_pc = (wave_mode == `WM_PC_FF) || (wave_mode == `WM_PC_A);
  wire is_fast = (wave_mode == `WM_FAST_FF) || (wave_mode == `WM_FAST_A);
  wire is_ctc = (wave_mode == `WM_CTC);
  wire is_pwm = is_pc | is_fast;
  wire top_from_a = (wave_mode == `WM_CTC) || (wave_mode == `WM_PC_A) || (wave_mode == `WM_FAST_A);
  wire [7:0] top_value = top_from_a ? match_value_a_ff : `CNT_MAX;
  wire at_top = tick && (count_value_ff == top_value);
  wire at_bottom = tick && (count_value_ff == `CNT_BOTTOM);
  wire at_max = tick && (count_value_ff == `CNT_MAX);
  // A counter write blocks the next match
  wire match_a = tick && !count_wr_ff && (count_value_ff == match_value_a_ff);
  wire match_b = tick && !count_wr_ff && (count_value_ff == match_value_b_ff);
  wire force_hit_a = force_a_ff && !is_pwm;
  wire force_hit_b = force_b_ff && !is_pwm;

  function [7:0] wr_merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    begin
      wr_merge = (old & ~mask) | (data & mask);
    end
  endfunction

  // Register select for one bus strobe
  function reg_hit;
    input strobe;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      reg_hit = strobe && (addr == ofs);
    end
  endfunction

  // Sticky flag: set wins over write-one-to-clear
  function flag_next;
    input set_evt;
    input old;
    input clr;
    begin
      flag_next = set_evt | (old & ~clr);
    end
  endfunction

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  reg [7:0] nxt_count;
  reg nxt_up;
  always @* begin
    nxt_count = count_value_ff;
    nxt_up = count_up_ff;
    if (tick) begin
      if (is_pc) begin
        // Top and bottom each held one tick by the direction turn
        if (count_up_ff && count_value_ff == top_value) nxt_up = 1'b0;
        else if (!count_up_ff && count_value_ff == `CNT_BOTTOM) nxt_up = 1'b1;
        if (count_up_ff && count_value_ff != top_value) nxt_count = count_value_ff + 8'h01;
        else if (!count_up_ff && count_value_ff != `CNT_BOTTOM) nxt_count = count_value_ff - 8'h01;
      end else if ((is_ctc || is_fast) && count_value_ff == top_value) begin
        nxt_count = `CNT_BOTTOM;
        nxt_up = 1'b1;
      end else begin
        nxt_count = count_value_ff + 8'h01;
        nxt_up = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Writes land at the edge where the master sees waitrequest low
  wire bus_wr = avs_write && !avs_waitrequest;
  // Read data is loaded one edge early so it stands when waitrequest drops
  wire bus_rd = avs_read && avs_waitrequest;
  wire wr_a = reg_hit(bus_wr, avs_address, `OFS_CTRL_A);
  wire wr_b = reg_hit(bus_wr, avs_address, `OFS_CTRL_B);
  wire wr_cnt = reg_hit(bus_wr, avs_address, `OFS_COUNT);
  wire wr_flags = reg_hit(bus_wr, avs_address, `OFS_FLAGS);
  wire wr_match_a = reg_hit(bus_wr, avs_address, `OFS_MATCH_A);
  wire wr_match_b = reg_hit(bus_wr, avs_address, `OFS_MATCH_B);
  wire wrap_evt = is_pc ? at_bottom : ((wave_mode == `WM_FAST_A) ? at_top : at_max);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_a_ff <= `CTRL_RST;
      ctrl_b_ff <= `CTRL_RST;
    end else begin
      if (wr_a) begin
        ctrl_a_ff <= wr_merge(ctrl_a_ff, avs_writedata[7:0], `CTRLA_WMASK);
      end
      if (wr_b) begin
        ctrl_b_ff <= wr_merge(ctrl_b_ff, avs_writedata[7:0], `CTRLB_WMASK);
      end
    end
  end

  // ----------------------------------------
  // Force strobes
  // ----------------------------------------
  // Strobes live one cycle and are never stored in control B
  always @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      force_a_ff <= 1'b0;
      force_b_ff <= 1'b0;
    end else begin
      force_a_ff <= wr_b && avs_writedata[`FB_FORCE_A];
      force_b_ff <= wr_b && avs_writedata[`FB_FORCE_B];
    end
  end

  // ----------------------------------------
  // Counter register
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      count_value_ff <= 8'h00;
      count_up_ff <= 1'b1;
      count_wr_ff <= 1'b0;
    end else begin
      if (wr_cnt) begin
        count_value_ff <= avs_writedata[7:0];
      end else begin
        count_value_ff <= nxt_count;
      end
      count_up_ff <= nxt_up;
      if (wr_cnt) begin
        count_wr_ff <= 1'b1;
      end else if (tick) begin
        count_wr_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Match registers
  // ----------------------------------------
  // Double buffer only in PWM, so a mid-period write cannot glitch the output
  always @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      match_value_a_ff <= 8'h00;
      match_value_b_ff <= 8'h00;
      match_buf_a_ff <= 8'h00;
      match_buf_b_ff <= 8'h00;
    end else begin
      if (wr_match_a) begin
        match_buf_a_ff <= avs_writedata[7:0];
      end
      if (wr_match_b) begin
        match_buf_b_ff <= avs_writedata[7:0];
      end
      if (!is_pwm || at_top) begin
        match_value_a_ff <= wr_match_a ? avs_writedata[7:0] : match_buf_a_ff;
        match_value_b_ff <= wr_match_b ? avs_writedata[7:0] : match_buf_b_ff;
      end
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      wrap_flag_ff <= 1'b0;
      match_flag_a_ff <= 1'b0;
      match_flag_b_ff <= 1'b0;
    end else begin
      wrap_flag_ff <= flag_next(wrap_evt, wrap_flag_ff, wr_flags & avs_writedata[0]);
      match_flag_a_ff <= flag_next(match_a, match_flag_a_ff, wr_flags & avs_writedata[1]);
      match_flag_b_ff <= flag_next(match_b, match_flag_b_ff, wr_flags & avs_writedata[2]);
    end
  end

  // ----------------------------------------
  // Bus answer: one wait cycle per access
  // ----------------------------------------
  always @(posedge ref_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (bus_rd) begin
        case (avs_address)
          `OFS_CTRL_A: avs_readdata <= {24'h000000, ctrl_a_ff & `CTRLA_WMASK};
          `OFS_CTRL_B: avs_readdata <= {24'h000000, ctrl_b_ff & `CTRLB_WMASK};
          `OFS_COUNT: avs_readdata <= {24'h000000, count_value_ff};
          `OFS_MATCH_A: avs_readdata <= {24'h000000, match_buf_a_ff};
          `OFS_MATCH_B: avs_readdata <= {24'h000000, match_buf_b_ff};
          `OFS_FLAGS: avs_readdata <= {29'h00000000, match_flag_b_ff, match_flag_a_ff, wrap_flag_ff};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  tick_select u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n_ff),
    .tick_source_sel(tick_source_sel),
    .ext_sync(ext_sync_ff),
    .tick(tick)
  );

  wave_out_unit u_out_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n_ff),
    .sel(out_a_action_sel),
    .allow_toggle(wave_mode_high),
    .is_pwm(is_pwm),
    .is_pc(is_pc),
    .count_up(count_up_ff),
    .match(match_a),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .match_is_top(is_pwm && match_value_a_ff == top_value),
    .force_hit(force_hit_a),
    .wave_out(wave_out_a),
    .drive_en(drive_en_a)
  );

  wave_out_unit u_out_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n_ff),
    .sel(out_b_action_sel),
    .allow_toggle(1'b0),
    .is_pwm(is_pwm),
    .is_pc(is_pc),
    .count_up(count_up_ff),
    .match(match_b),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .match_is_top(is_pwm && match_value_b_ff == top_value),
    .force_hit(force_hit_b),
    .wave_out(wave_out_b),
    .drive_en(drive_en_b)
  );
endmodule // timer8_wave_ctrl

// ---- dv/port_pin_model.sv ----
// Purpose: Port pin with a weak pull-up, driven by the compare output or the port latch
// Assumes: Direction bit and port latch are held outside the timer
// Notes: A released pin shows the pull-up level, never the last driven value
`timescale 1ns/100ps
module port_pin_model (
  input wire wave_out,
  input wire drive_en,
  input wire dir_out,
  input wire port_value,
  output wire pin
);
  assign pin = dir_out ? (drive_en ? wave_out : port_value) : 1'b1;
endmodule // port_pin_model

// ---- dv/timer8_wave_ctrl_assertions.sv ----
// Purpose: Port assertions for the waveform timer control block
// Assumes: Shadow copies of control writes track the block
// Notes: Takeover and stop checks wait seven quiet cycles so register latency never matters; force checks use a 1 to 4 cycle window
`timescale 1ns/100ps
module timer8_wave_ctrl_chk (
  input wire ref_clk,
  input wire arst_n,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire wave_out_a,
  input wire wave_out_b,
  input wire drive_en_a,
  input wire drive_en_b
);
  reg [7:0] ctl_a_ff;
  reg [7:0] ctl_b_ff;
  reg [2:0] quiet_ff;
  wire take_wr = avs_write && !avs_waitrequest;
  wire pwm = ctl_a_ff[0];
  wire en_a_exp = (ctl_a_ff[7:6] != 2'b00) && !(pwm && ctl_a_ff[7:6] == 2'b01 && !ctl_b_ff[3]);
  wire en_b_exp = (ctl_a_ff[5:4] != 2'b00) && !(pwm && ctl_a_ff[5:4] == 2'b01);
  wire fwr = take_wr && avs_address == 5'h04;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_a_ff <= 8'h00;
      ctl_b_ff <= 8'h00;
      quiet_ff <= 3'h0;
    end else begin
      if (take_wr && avs_address == 5'h00)
        ctl_a_ff <= avs_writedata[7:0];
      if (fwr)
        ctl_b_ff <= avs_writedata[7:0];
      if (take_wr)
        quiet_ff <= 3'h0;
      else if (quiet_ff != 3'h7)
        quiet_ff <= quiet_ff + 3'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  ack_quick_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rsv_a_zero_a: assert property (avs_read && avs_waitrequest && avs_address == 5'h00
    |=> avs_readdata[31:8] == 24'h0 && avs_readdata[3:2] == 2'b00) else $error("ctrl a reserved bits set");
  rsv_b_zero_a: assert property (avs_read && avs_waitrequest && avs_address == 5'h04
    |=> avs_readdata[7:4] == 4'h0) else $error("ctrl b strobe or reserved bits set");
  take_a_a: assert property (quiet_ff == 3'h7 |-> drive_en_a == en_a_exp)
    else $error("pin a takeover wrong");
  take_b_a: assert property (quiet_ff == 3'h7 |-> drive_en_b == en_b_exp)
    else $error("pin b takeover wrong");
  stop_hold_a: assert property (quiet_ff == 3'h7 && ctl_b_ff[2:0] == 3'h0
    |-> $stable(wave_out_a) && $stable(wave_out_b)) else $error("output moved while stopped");
  force_set_a: assert property (fwr && avs_writedata[7] && !pwm && ctl_a_ff[7:6] == 2'b11
    |-> ##[1:4] wave_out_a) else $error("forced set on a missing");
  force_clr_b_a: assert property (fwr && avs_writedata[6] && !pwm && ctl_a_ff[5:4] == 2'b10
    |-> ##[1:4] !wave_out_b) else $error("forced clear on b missing");
  pwm_noforce_a: assert property (fwr && avs_writedata[7] && pwm && avs_writedata[2:0] == 3'h0
    && ctl_b_ff[2:0] == 3'h0 |=> $stable(wave_out_a) [*4]) else $error("force acted in pwm mode");
endmodule // timer8_wave_ctrl_chk

bind timer8_wave_ctrl timer8_wave_ctrl_chk chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_out_a(wave_out_a),
  .wave_out_b(wave_out_b), .drive_en_a(drive_en_a), .drive_en_b(drive_en_b));

// ---- dv/tb_timer8_wave_ctrl.sv ----
// Purpose: Self-checking bench for the waveform timer control block
// Assumes: Avalon-MM slave answers one cycle after taking a request
// Notes: Only the first duty window spans whole periods; the duty ranges absorb the phase in the others
`timescale 1ns/100ps
`include "timer8_defs.vh"
module tb_timer8_wave_ctrl;
  reg ref_clk;
  reg arst_n;
  reg [4:0] avs_address;
  reg avs_read;
  reg avs_write;
  reg [31:0] avs_writedata;
  reg ext_tick_pin;
  reg dir_a;
  reg dir_b;
  reg port_value;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire wave_out_a;
  wire wave_out_b;
  wire drive_en_a;
  wire drive_en_b;
  wire pin_a;
  wire pin_b;
  integer err_total;
  integer n_compared;
  integer cyc;
  integer m;
  integer s;
  integer c;
  integer hi_n;
  integer same_n;
  reg [7:0] q;
  int len_t[8] = '{40, 40, 64, 256, 1024, 2048, 0, 0};
  int lo_t[8] = '{0, 40, 8, 3, 3, 1, 10, 10};
  int hi_t[8] = '{0, 52, 10, 5, 5, 3, 10, 10};
  timer8_wave_ctrl dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_tick_pin(ext_tick_pin), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .drive_en_a(drive_en_a), .drive_en_b(drive_en_b));
  port_pin_model pin_a_u (.wave_out(wave_out_a), .drive_en(drive_en_a), .dir_out(dir_a),
    .port_value(port_value), .pin(pin_a));
  port_pin_model pin_b_u (.wave_out(wave_out_b), .drive_en(drive_en_b), .dir_out(dir_b),
    .port_value(port_value), .pin(pin_b));
  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task bus(input wr, input [4:0] a, input [7:0] d, output [7:0] r);
    begin
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
        @(posedge ref_clk);
      r = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    reg [7:0] t;
    bus(1'b1, a, d, t);
  endtask
  task chk_eq(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task chk_rng(input [31:0] v, input [31:0] lo, input [31:0] hi);
    begin
      n_compared = n_compared + 1;
      if ((v >= lo && v <= hi) !== 1'b1) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: %0d outside %0d..%0d", $time, v, lo, hi);
      end
    end
  endtask
  task rd_chk(input [4:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00, q);
      chk_eq(q, e);
    end
  endtask
  // Strobes both outputs with the clock stopped and checks the pins
  task force_chk(input [7:0] ca, input e);
    begin
      wr(`OFS_CTRL_A, ca);
      wr(`OFS_CTRL_B, 8'hc0);
      repeat (3) @(posedge ref_clk);
      chk_eq(pin_a, e);
      chk_eq(pin_b, e);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    begin
      rd_chk(`OFS_CTRL_A, 8'h00);
      rd_chk(`OFS_CTRL_B, 8'h00);
      chk_eq(pin_a, 1'b1);
      $display("t_reset finished");
    end
  endtask
  task t_layout;
    begin
      wr(`OFS_CTRL_A, 8'hff);
      rd_chk(`OFS_CTRL_A, 8'hf3);
      wr(`OFS_CTRL_B, 8'hf8);
      rd_chk(`OFS_CTRL_B, 8'h08);
      wr(5'h18, 8'h5a);
      rd_chk(5'h18, 8'h00);
      $display("t_layout finished");
    end
  endtask
  task t_drive;
    for (m = 0; m < 8; m = m + 1) begin
      for (s = 0; s < 4; s = s + 1) begin
        wr(`OFS_CTRL_A, {s[1:0], s[1:0], 2'b00, m[1:0]});
        wr(`OFS_CTRL_B, {4'h0, m[2], 3'h0});
        repeat (3) @(posedge ref_clk);
        chk_eq(drive_en_a, s != 0 && !(m[0] && s == 1 && !m[2]));
        chk_eq(drive_en_b, s != 0 && !(m[0] && s == 1));
      end
    end
    $display("t_drive finished");
  endtask
  task t_force;
    begin
      dir_a <= 1'b1;
      dir_b <= 1'b1;
      force_chk(8'hf0, 1'b1);
      force_chk(8'ha0, 1'b0);
      force_chk(8'h50, 1'b1);
      rd_chk(`OFS_CTRL_B, 8'h00);
      force_chk(8'ha3, 1'b1);
      $display("t_force finished");
    end
  endtask
  // A clears on match, B sets on match: the two must always differ
  task t_duty(input [1:0] ml, input mh, input [7:0] mv, input integer win, lo, hi);
    begin
      wr(`OFS_CTRL_B, 8'h00);
      wr(`OFS_CTRL_A, 8'h00);
      wr(`OFS_MATCH_A, mv);
      wr(`OFS_MATCH_B, mv);
      wr(`OFS_COUNT, 8'h00);
      wr(`OFS_FLAGS, 8'h07);
      rd_chk(`OFS_FLAGS, 8'h00);
      wr(`OFS_CTRL_A, {4'hb, 2'b00, ml});
      wr(`OFS_CTRL_B, {4'h0, mh, 3'h1});
      repeat (600) @(posedge ref_clk);
      hi_n = 0;
      same_n = 0;
      repeat (win) begin
        @(posedge ref_clk);
        hi_n = hi_n + (wave_out_a === 1'b1);
        same_n = same_n + (wave_out_a === wave_out_b);
      end
      wr(`OFS_CTRL_B, 8'h00);
      chk_rng(hi_n, lo, hi);
      chk_eq(same_n, 0);
      rd_chk(`OFS_FLAGS, 8'h07);
      $display("t_duty finished");
    end
  endtask
  task t_clock;
    begin
      wr(`OFS_CTRL_A, 8'h00);
      for (c = 0; c < 8; c = c + 1) begin
        wr(`OFS_COUNT, 8'h00);
        wr(`OFS_CTRL_B, c[7:0]);
        rd_chk(`OFS_CTRL_B, c[7:0]);
        if (c >= 6) begin
          repeat (10) begin
            ext_tick_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_tick_pin <= 1'b0;
            repeat (4) @(posedge ref_clk);
          end
        end else
          repeat (len_t[c]) @(posedge ref_clk);
        wr(`OFS_CTRL_B, 8'h00);
        bus(1'b0, `OFS_COUNT, 8'h00, q);
        chk_rng({24'h0, q}, lo_t[c], hi_t[c]);
      end
      $display("t_clock finished");
    end
  endtask
  task final_report;
    begin
      $display("compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  initial begin
    {err_total, n_compared, cyc} = 0;
    {arst_n, avs_read, avs_write, ext_tick_pin, dir_a, dir_b, port_value} = 0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset;
    t_layout;
    t_drive;
    t_force;
    t_duty(2'b11, 1'b0, 8'h40, 1024, 256, 260);
    t_duty(2'b01, 1'b0, 8'h40, 1020, 252, 260);
    t_duty(2'b11, 1'b1, 8'h80, 1024, 1024, 1024);
    t_clock;
    final_report;
  end
endmodule // tb_timer8_wave_ctrl
